// [rtl/uhmp_pin_logic.v]
// host select, modem status register, interrupt and modem control pin logic
// assumes mclk drives all logic; bus strobes and modem pins are asynchronous
`timescale 1ns/10ps
`include "uhmp_consts.vh"

// Functional notes
// - selected while both high selects high and low select low, or while strobe high holds such a latched select
// - modem status bit 4 shows current clear-to-send condition
// - modem status bit 0 set on clear-to-send change since last read
// - clear-to-send change interrupts only if enabled and auto flow control off
// - with auto flow control on, clear-to-send gates the transmitter
// - bit 7 shows carrier detect, bit 3 flags change, interrupts if enabled
// - data-set-ready change flagged and interrupts when enabled
// - transceiver_off_n low whenever host is not reading
// - terminal-ready low when control bit set; high on reset, loopback, clear
// - interrupt high for receive error, data (only with fifo_mode set), transmit empty, modem change
// - interrupt drops when serviced or on master reset
// - master reset clears registers and forces reset output levels
// - data lines driven only while returning read data
// - address strobe high holds selects latched at its rising edge
module uhmp_pin_logic
(
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       master_reset_in,
   input  wire       address_strobe_n,
   input  wire [2:0] reg_addr,
   input  wire       select_high_a,
   input  wire       select_high_b,
   input  wire       select_low_n,
   input  wire       read_n,
   input  wire       read,
   input  wire       cts_n,
   input  wire       dsr_n,
   input  wire       ri_n,
   input  wire       dcd_n,
   input  wire       dtr_ctrl,
   input  wire       loopback,
   input  wire       modem_int_en,
   input  wire       auto_cts_en,
   input  wire       rx_error_irq,
   input  wire       rx_data_irq,
   input  wire       tx_empty_irq,
   input  wire       fifo_mode,
   input  wire       modem_irq_ack,
   output reg  [7:0] data_out,
   output reg        data_oe_n,
   output reg        transceiver_off_n,
   output reg        dtr_n,
   output reg        irq,
   output reg        tx_permit
);

   reg  [3:0] s1_q;
   reg  [3:0] s2_q;
   reg  [3:0] prev_q;
   reg  [2:0] ctl1_q;
   reg  [2:0] ctl2_q;
   reg  [5:0] sel1_q;
   reg  [5:0] sel2_q;
   reg  [2:0] lat_addr_q;
   reg        lat_sel_q;
   reg  [3:0] flag_q;
   reg  [3:0] flag_d;
   reg        rd_prev_q;
   reg        modem_pend_q;
   wire [2:0] eff_addr;
   wire       eff_sel;
   wire       rd_act;
   wire       rd_start;
   wire       msr_rd;
   wire [7:0] msr_val;
   wire [3:0] chg;
   wire       mr;
   wire       chip_sel;
   wire [2:0] sync_addr;

   // ordering of sync bits: cts, dsr, ri, dcd (all active-low pins)
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q   <= `UHMP_SYNC_RST;
         s2_q   <= `UHMP_SYNC_RST;
         ctl1_q <= 3'h0;
         ctl2_q <= 3'h0;
      end
      else
      begin
         s1_q   <= {dcd_n, ri_n, dsr_n, cts_n};
         s2_q   <= s1_q;
         ctl1_q <= {master_reset_in, (!read_n) | read, address_strobe_n};
         ctl2_q <= ctl1_q;
      end
   end

   // address and selects take the same two-flop delay as the strobes, so the
   // strobe latch captures selects of the very instant the strobe rose
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel1_q <= `UHMP_SEL_SYNC_RST;
         sel2_q <= `UHMP_SEL_SYNC_RST;
      end
      else
      begin
         sel1_q <= {select_low_n, select_high_b, select_high_a, reg_addr};
         sel2_q <= sel1_q;
      end
   end

   // true when both high selects are high and the low select is low
   function sel_decode;
      input [2:0] sel;
      begin
         sel_decode = sel[0] & sel[1] & ~sel[2];
      end
   endfunction

   assign mr     = ctl2_q[2];
   assign rd_act = ctl2_q[1];
   assign chip_sel  = sel_decode(sel2_q[5:3]);
   assign sync_addr = sel2_q[2:0];

   // latch on rising strobe; tracks while low, so last low value is held
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lat_addr_q <= 3'h0;
         lat_sel_q  <= 1'b0;
      end
      else
      begin
         if (!ctl2_q[0])
         begin
            lat_addr_q <= sync_addr;
            lat_sel_q  <= chip_sel;
         end
      end
   end

   assign eff_addr = ctl2_q[0] ? lat_addr_q : sync_addr;
   assign eff_sel  = ctl2_q[0] ? lat_sel_q : chip_sel;
   assign rd_start = rd_act & ~rd_prev_q & eff_sel;
   assign msr_rd   = rd_start & (eff_addr == `UHMP_MSR_ADDR);

   // change detection; ri flags trailing edge only
   assign chg = {prev_q[3] ^ s2_q[3],
                 ~prev_q[2] & s2_q[2],
                 prev_q[1] ^ s2_q[1],
                 prev_q[0] ^ s2_q[0]};

   always @*
   begin
      flag_d = flag_q;
      // read clears, a change in the same cycle still wins
      if (msr_rd)
         flag_d = 4'h0;
      flag_d = flag_d | chg;
   end

   // status bits are true-sense of the low-active pins
   assign msr_val = {~s2_q, flag_q[3], flag_q[2], flag_q[1], flag_q[0]};

   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_q       <= `UHMP_SYNC_RST;
         flag_q       <= 4'h0;
         rd_prev_q    <= 1'b0;
         modem_pend_q <= 1'b0;
         data_out     <= `UHMP_MSR_RST;
         data_oe_n    <= 1'b1;
         transceiver_off_n <= 1'b0;
         dtr_n        <= 1'b1;
         irq          <= 1'b0;
         tx_permit    <= 1'b1;
      end
      else if (mr)
      begin
         prev_q       <= s2_q;
         flag_q       <= 4'h0;
         rd_prev_q    <= rd_act;
         modem_pend_q <= 1'b0;
         data_out     <= `UHMP_MSR_RST;
         data_oe_n    <= 1'b1;
         transceiver_off_n <= 1'b0;
         dtr_n        <= 1'b1;
         irq          <= 1'b0;
         tx_permit    <= 1'b1;
      end
      else
      begin
         prev_q    <= s2_q;
         flag_q    <= flag_d;
         rd_prev_q <= rd_act;
         if (msr_rd)
            data_out <= msr_val;
         // drive data only while reading selected device
         data_oe_n <= ~(rd_act & eff_sel);
         transceiver_off_n <= rd_act & eff_sel;
         dtr_n <= ~(dtr_ctrl & ~loopback);
         // modem interrupt source; set beats acknowledge
         if ((modem_int_en & ((chg[0] & ~auto_cts_en) | (|chg[3:1]))) )
            modem_pend_q <= 1'b1;
         // serviced by status read or acknowledge
         else if (msr_rd | modem_irq_ack)
            modem_pend_q <= 1'b0;
         irq <= rx_error_irq | (rx_data_irq & fifo_mode) | tx_empty_irq |
                (modem_pend_q & modem_int_en);
         tx_permit <= ~auto_cts_en | ~s2_q[0];
      end
   end

endmodule

// [rtl/uhmp_consts.vh]
// constants for the host select, modem status and interrupt pin logic
// included by rtl/uhmp_pin_logic.v only
`ifndef UHMP_CONSTS_VH
`define UHMP_CONSTS_VH
`define UHMP_MSR_ADDR      3'h6
`define UHMP_MSR_D_CTS     0
`define UHMP_MSR_D_DSR     1
`define UHMP_MSR_TE_RI     2
`define UHMP_MSR_D_DCD     3
`define UHMP_MSR_CTS       4
`define UHMP_MSR_DSR       5
`define UHMP_MSR_RI        6
`define UHMP_MSR_DCD       7
`define UHMP_MSR_RST       8'h00
`define UHMP_SYNC_RST      4'hf
`define UHMP_SEL_SYNC_RST  6'h00
`endif

// [dv/uhmp_modem.sv]
// modem side model: drives the four status pins
// the bench moves the pins by name between reads
`timescale 1ns/10ps
module uhmp_modem
(
   input  wire dtr_n,
   output reg  cts_n,
   output reg  dsr_n,
   output reg  ri_n,
   output reg  dcd_n
);
   initial {cts_n, dsr_n, ri_n, dcd_n} = 4'hf;
endmodule

// [dv/uhmp_pin_logic_assertions.sv]
// checker on the pin logic ports
// read_n is held inactive by the bench
`timescale 1ns/10ps
module uhmp_pin_logic_assertions
(
   input wire mclk,
   input wire rst_n,
   input wire master_reset_in,
   input wire read,
   input wire cts_n,
   input wire dtr_ctrl,
   input wire loopback,
   input wire auto_cts_en,
   input wire data_oe_n,
   input wire transceiver_off_n,
   input wire dtr_n,
   input wire irq,
   input wire tx_permit
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   oe_xcv_a: assert property (!data_oe_n |-> transceiver_off_n) else $error("oe");
   oe_cause_a: assert property ($fell(data_oe_n) |-> $past(read)) else $error("rd");
   xcv_idle_a: assert property (!read [*5]
      |-> !transceiver_off_n && data_oe_n) else $error("transceiver active while idle");
   dtr_on_a: assert property ((dtr_ctrl && !loopback && !master_reset_in) [*5]
      |-> !dtr_n) else $error("terminal ready not active");
   dtr_off_a: assert property ((!dtr_ctrl || loopback) [*5] |-> dtr_n) else $error("d");
   mr_out_a: assert property (master_reset_in [*4] |-> !irq && dtr_n) else $error("mr");
   tx_hold_a: assert property ((auto_cts_en && cts_n && !master_reset_in) [*5]
      |-> !tx_permit) else $error("transmitter not held off");
   tx_go_a: assert property ((auto_cts_en && !cts_n) [*5]
      |-> tx_permit) else $error("transmitter not permitted");
   cover property (!data_oe_n);
   cover property (irq);
   cover property (!dtr_n && !tx_permit);
endmodule
bind uhmp_pin_logic uhmp_pin_logic_assertions chk_i (.*);

// [dv/uhmp_pin_logic_tb.sv]
// bench for the pin logic: status reads, modem changes, interrupts, control pins
// inputs move on falling edges; reads go to the status register and to address 1
`timescale 1ns/10ps
module uhmp_pin_logic_tb;
   reg        mclk, rst_n, mr, as_n, sa, sb, sl_n, rd, dc, lb, mie, ac, rxe, ack;
   reg  [2:0] ad;
   reg  [8:0] v;
   wire [7:0] dq;
   wire       oe_n, xo_n, dtr_n, irq, txp, cts_n, dsr_n, ri_n, dcd_n;
   integer    n_errors = 0, n_tests = 0;
   uhmp_modem m(.dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));
   uhmp_pin_logic uut(.mclk(mclk), .rst_n(rst_n), .master_reset_in(mr),
      .address_strobe_n(as_n), .reg_addr(ad), .select_high_a(sa), .select_high_b(sb),
      .select_low_n(sl_n), .read_n(1'h1), .read(rd), .cts_n(cts_n), .dsr_n(dsr_n),
      .ri_n(ri_n), .dcd_n(dcd_n), .dtr_ctrl(dc), .loopback(lb), .modem_int_en(mie),
      .auto_cts_en(ac), .rx_error_irq(rxe), .rx_data_irq(1'h0), .tx_empty_irq(1'h0),
      .fifo_mode(1'h0), .modem_irq_ack(ack), .data_out(dq), .data_oe_n(oe_n),
      .transceiver_off_n(xo_n), .dtr_n(dtr_n), .irq(irq), .tx_permit(txp));
   initial
   begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   task chk(input [9:0] g, input [9:0] e);
   begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("ERROR %0t %h %h", $time, g, e);
      end
   end
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge mclk);
   endtask
   // one read, 5 edges each way to cover sync
   task rdc;
   begin
      rd = 1;
      cyc(5);
      v = {oe_n, dq};
      rd = 0;
      cyc(5);
   end
   endtask
   task t_read;
   begin
      as_n = 1;
      cyc(3);
      sa = 0;
      ad = 3'h0;
      m.cts_n = 0;
      cyc(5);
      rdc;
      chk(v, 9'h011);
      rdc;
      chk(v, 9'h010);
      as_n = 0;
      sa = 1;
      ad = 3'h1;
      m.cts_n = 1;
      cyc(5);
      rdc;
      chk(v, 9'h010);
      ad = 3'h6;
      rdc;
      chk(v, 9'h001);
      m.cts_n = 0;
      cyc(5);
      rdc;
      chk(v, 9'h011);
      $display("read end");
   end
   endtask
   task t_irq;
   begin
      sl_n = 1;
      m.dcd_n = 0;
      cyc(5);
      rdc;
      chk(v[8], 1);
      sl_n = 0;
      mie = 1;
      rdc;
      chk(v, 9'h098);
      m.dsr_n = 0;
      cyc(8);
      chk(irq, 1);
      rdc;
      chk({irq, v}, 10'h0b2);
      ac = 1;
      m.cts_n = 1;
      cyc(8);
      chk({irq, txp}, 0);
      m.cts_n = 0;
      cyc(6);
      chk(txp, 1);
      ac = 0;
      rxe = 1;
      cyc(2);
      chk(irq, 1);
      rxe = 0;
      cyc(2);
      chk(irq, 0);
      m.cts_n = 1;
      cyc(8);
      chk(irq, 10'h001);
      ack = 1;
      cyc(1);
      ack = 0;
      cyc(3);
      chk(irq, 10'h000);
      $display("irq end");
   end
   endtask
   task t_pins;
   begin
      dc = 1;
      cyc(4);
      chk(dtr_n, 0);
      lb = 1;
      cyc(4);
      chk(dtr_n, 1);
      lb = 0;
      mr = 1;
      cyc(5);
      chk({dtr_n, irq}, 2);
      mr = 0;
      $display("pins end");
   end
   endtask
   task wrap_up;
   begin
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   initial
   begin
      {rst_n, mr, as_n, sa, sb, sl_n, rd, dc, lb, mie, ac, rxe} = 12'h180;
      ad = 3'h6;
      ack = 1'h0;
      cyc(16);
      rst_n = 1;
      cyc(3);
      t_read;
      t_irq;
      t_pins;
      wrap_up;
   end
   initial
   begin
      #50000;
      n_errors = n_errors + 1;
      wrap_up;
   end
endmodule
